// *** shared/sbt_pkg.sv ***
package sbt_pkg;
    // Register indices on the plain register port
    localparam logic [1:0] SBT_ADDR_LOW = 2'h0;
    localparam logic [1:0] SBT_ADDR_HIGH = 2'h1;
    localparam logic [1:0] SBT_ADDR_CTRL = 2'h2;
    localparam logic [1:0] SBT_ADDR_STAT = 2'h3;
    // Status register field positions
    localparam int SBT_STAT_FLAG_BIT = 0;
    localparam int SBT_STAT_IE_BIT = 1;
    // Reset values
    localparam logic [15:0] SBT_COUNT_RST = 16'h0000;
    localparam logic [7:0] SBT_BYTE_RST = 8'h00;
    localparam logic [2:0] SBT_PRE_RST = 3'h0;
    // System clocks per instruction cycle (Fosc/4)
    localparam int SBT_INSTR_DIV = 4;
    // Compare mode that fires the special event trigger
    localparam logic [3:0] SBT_MODE_SPECIAL = 4'hb;
    localparam logic [15:0] SBT_COUNT_MAX = 16'hffff;

    // Control register layout, bit 7 down to bit 0
    typedef struct packed {
        logic wide_access_enable;
        logic unused;
        logic [1:0] input_prescale_select;
        logic compare_timebase_select;
        logic external_sync_bypass;
        logic clock_source_select;
        logic counter_on;
    } sbt_ctrl_s;

    localparam sbt_ctrl_s SBT_CTRL_RST = '0;

    // Register port request
    typedef struct packed {
        logic [1:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } sbt_req_s;
endpackage

// *** hdl/sbt_timer.sv ***
`timescale 1ns/1ps
// Function
// - Internal source counts every instruction cycle
// - External source counts pin or oscillator edges
// - Oscillator pins read zero while oscillator on
// - Wide low-byte read copies high byte to buffer
// - Wide writes: high buffers, low loads both
// - Wide mode hides real high byte
// - Low write clears prescaler, high does not
// - Count wraps FFFFh to 0000h, sets flag
// - Flag sticky; request only when enabled
// - Special compare trigger resets the counter
// - Write beats simultaneous trigger reset
// - Prescale codes divide by 1,2,4,8
// - Narrow mode: two independent byte registers
// - Sync bypass chooses synchronous or asynchronous
// - Counter on bit runs or holds count
module sbt_timer (
    input wire logic clock,
    input wire logic arst_n,
    input sbt_pkg::sbt_req_s req,
    output logic [7:0] rdata,
    input wire logic external_clock_pin,
    input wire logic sec_osc_clock,
    input wire logic secondary_osc_enable,
    input wire logic [1:0] osc_pin_in,
    input wire logic [1:0] osc_pin_direction_bits,
    output logic [1:0] osc_pin_read,
    input wire logic [3:0] compare_mode_field,
    input wire logic compare_match,
    output logic compare_timebase_select,
    output logic overflow_irq
);
    import sbt_pkg::*;

    // Prescaler terminal count for a select code
    function automatic logic [2:0] pre_last(input logic [1:0] sel);
        pre_last = 3'((1 << sel) - 1);
    endfunction

    sbt_ctrl_s ctrl; // Control register
    logic [15:0] count; // The counter pair
    logic [7:0] high_buf; // High byte buffer
    logic [2:0] pre; // Prescaler count
    logic [1:0] div; // Instruction cycle divider
    logic overflow_flag; // Sticky overflow
    logic overflow_int_enable; // Interrupt gate
    logic [2:0] ext_sync; // Clock pin synchroniser
    logic [2:0] osc_sync; // Oscillator synchroniser
    logic [1:0] pa_sync1; // Oscillator pin sync stage one
    logic [1:0] pa_sync2; // Oscillator pin sync stage two
    logic [1:0] pa_sync3; // Oscillator pin sync stage three
    logic [1:0] pa_level; // Filtered pin level
    logic src_level; // Filtered external level
    logic src_s2; // Chosen source, second stage
    logic src_s3; // Chosen source, third stage
    logic instr_tick; // One per instruction cycle
    logic ext_edge; // Rising edge of the external source
    logic count_tick; // Raw count clock
    logic pre_out; // Prescaled increment
    logic wr_low; // Write to low byte
    logic wr_high; // Write to high byte
    logic trig_reset; // Special event reset request
    logic [15:0] next_count; // Counter next value

    // Decode of register strobes
    assign wr_low = req.wr && req.addr == SBT_ADDR_LOW;
    assign wr_high = req.wr && req.addr == SBT_ADDR_HIGH;

    // Instruction cycle divider; free running, so Fosc/4 phase is fixed
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            div <= 2'h0;
        end else begin
            div <= 2'(div + 2'h1);
        end
    end
    assign instr_tick = div == 2'(SBT_INSTR_DIV - 1);

    // Pin synchronisers; stage one feeds stage two only
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            ext_sync <= 3'h0;
            osc_sync <= 3'h0;
            pa_sync1 <= 2'h0;
            pa_sync2 <= 2'h0;
            pa_sync3 <= 2'h0;
        end else begin
            ext_sync <= {ext_sync[1:0], external_clock_pin};
            osc_sync <= {osc_sync[1:0], sec_osc_clock};
            pa_sync1 <= osc_pin_in;
            pa_sync2 <= pa_sync1;
            pa_sync3 <= pa_sync2;
        end
    end

    // Oscillator takes over the clock when enabled
    assign src_s2 = secondary_osc_enable ? osc_sync[1] : ext_sync[1];
    assign src_s3 = secondary_osc_enable ? osc_sync[2] : ext_sync[2];

    // Filtered level moves only when stages two and three agree
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            src_level <= 1'b0;
            pa_level <= 2'h0;
        end else begin
            if (src_s2 == src_s3) begin
                src_level <= src_s3;
            end
            for (int i = 0; i < 2; i++) begin
                if (pa_sync2[i] == pa_sync3[i]) begin
                    pa_level[i] <= pa_sync3[i];
                end
            end
        end
    end

    // Bypass takes the raw stage edge a cycle sooner, without the filter
    always_comb begin
        if (ctrl.external_sync_bypass) begin
            ext_edge = src_s2 && !src_s3;
        end else begin
            ext_edge = src_s2 && src_s3 && !src_level;
        end
    end

    // Source select; bypass bit has no effect on the internal path
    assign count_tick = ctrl.clock_source_select ? ext_edge : instr_tick;

    // Digital input cut off while the oscillator owns the pins
    // Direction bits are deliberately not consulted
    assign osc_pin_read = secondary_osc_enable ? 2'h0 : pa_level;

    // Prescaler; gated by the on bit, cleared by low-byte writes only
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            pre <= SBT_PRE_RST;
        end else if (wr_low) begin
            pre <= SBT_PRE_RST;
        end else if (ctrl.counter_on && count_tick) begin
            if (pre >= pre_last(ctrl.input_prescale_select)) begin
                pre <= SBT_PRE_RST;
            end else begin
                pre <= 3'(pre + 3'h1);
            end
        end
    end
    assign pre_out = ctrl.counter_on && count_tick &&
        pre >= pre_last(ctrl.input_prescale_select);

    // Trigger only when this counter is the compare time base
    assign trig_reset = compare_match && ctrl.compare_timebase_select &&
        compare_mode_field == SBT_MODE_SPECIAL;

    // Counter next value; writes first, then trigger, then count
    always_comb begin
        next_count = count;
        if (wr_low) begin
            if (ctrl.wide_access_enable) begin
                next_count = {high_buf, req.wdata};
            end else begin
                next_count[7:0] = req.wdata;
            end
        end else if (wr_high && !ctrl.wide_access_enable) begin
            next_count[15:8] = req.wdata;
        end else if (trig_reset) begin
            next_count = SBT_COUNT_RST;
        end else if (pre_out) begin
            next_count = 16'(count + 16'h0001);
        end
    end

    // Counter register
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            count <= SBT_COUNT_RST;
        end else begin
            count <= next_count;
        end
    end

    // High byte buffer: loaded by wide low reads and wide high writes
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            high_buf <= SBT_BYTE_RST;
        end else if (ctrl.wide_access_enable) begin
            if (wr_high) begin
                high_buf <= req.wdata;
            end else if (req.rd && req.addr == SBT_ADDR_LOW) begin
                high_buf <= count[15:8];
            end
        end
    end

    // Control register
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            ctrl <= SBT_CTRL_RST;
        end else if (req.wr && req.addr == SBT_ADDR_CTRL) begin
            ctrl <= req.wdata;
            ctrl.unused <= 1'b0; // Unimplemented bit stays zero
        end
    end
    assign compare_timebase_select = ctrl.compare_timebase_select;

    // Overflow flag; a wrap in the clearing cycle still sets it
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            overflow_flag <= 1'b0;
            overflow_int_enable <= 1'b0;
        end else begin
            if (req.wr && req.addr == SBT_ADDR_STAT) begin
                overflow_flag <= req.wdata[SBT_STAT_FLAG_BIT];
                overflow_int_enable <= req.wdata[SBT_STAT_IE_BIT];
            end
            if (pre_out && !wr_low && !wr_high && !trig_reset &&
                count == SBT_COUNT_MAX) begin
                overflow_flag <= 1'b1;
            end
        end
    end
    assign overflow_irq = overflow_flag && overflow_int_enable;

    // Read data, one cycle after the strobe
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            rdata <= SBT_BYTE_RST;
        end else if (req.rd) begin
            unique case (req.addr)
                SBT_ADDR_LOW: rdata <= count[7:0];
                SBT_ADDR_HIGH: begin
                    if (ctrl.wide_access_enable) begin
                        rdata <= high_buf;
                    end else begin
                        rdata <= count[15:8];
                    end
                end
                SBT_ADDR_CTRL: rdata <= ctrl;
                SBT_ADDR_STAT: begin
                    rdata <= {6'h00, overflow_int_enable, overflow_flag};
                end
            endcase
        end else begin
            rdata <= SBT_BYTE_RST;
        end
    end

    // Checks next to the logic they guard
    sequence s_wide_low_write;
        ctrl.wide_access_enable && wr_low;
    endsequence

    property p_wrap_flag;
        @(posedge clock) disable iff (!arst_n)
        (pre_out && !req.wr && !trig_reset && count == SBT_COUNT_MAX)
            |=> (count == 16'h0000 && overflow_flag);
    endproperty
    a_wrap_flag: assert property (p_wrap_flag) else $error("wrap lost flag");

    property p_flag_sticky;
        @(posedge clock) disable iff (!arst_n)
        (overflow_flag && !(req.wr && req.addr == SBT_ADDR_STAT)) |=> overflow_flag;
    endproperty
    a_flag_sticky: assert property (p_flag_sticky) else $error("flag dropped");

    // Request may only appear after a wrap or a status write opened it
    property p_irq_gate;
        @(posedge clock) disable iff (!arst_n)
        $rose(overflow_irq) |-> ($past(req.wr && req.addr == SBT_ADDR_STAT) ||
            $past(pre_out && count == SBT_COUNT_MAX));
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("irq not gated");

    property p_wide_load;
        @(posedge clock) disable iff (!arst_n)
        s_wide_low_write |=> count == {$past(high_buf), $past(req.wdata)};
    endproperty
    a_wide_load: assert property (p_wide_load) else $error("wide load wrong");

    property p_copy_high;
        @(posedge clock) disable iff (!arst_n)
        (ctrl.wide_access_enable && req.rd && req.addr == SBT_ADDR_LOW && !req.wr)
            |=> high_buf == $past(count[15:8]);
    endproperty
    a_copy_high: assert property (p_copy_high) else $error("buffer not copied");

    property p_high_hidden;
        @(posedge clock) disable iff (!arst_n)
        (ctrl.wide_access_enable && wr_high && !trig_reset && !pre_out)
            |=> count == $past(count);
    endproperty
    a_high_hidden: assert property (p_high_hidden) else $error("high byte reached");

    property p_pre_clear;
        @(posedge clock) disable iff (!arst_n)
        wr_low |=> pre == 3'h0;
    endproperty
    a_pre_clear: assert property (p_pre_clear) else $error("prescaler kept");

    property p_hold_off;
        @(posedge clock) disable iff (!arst_n)
        (!ctrl.counter_on && !req.wr && !trig_reset) |=> count == $past(count);
    endproperty
    a_hold_off: assert property (p_hold_off) else $error("counted while off");

    property p_trig;
        @(posedge clock) disable iff (!arst_n)
        (trig_reset && !req.wr) |=> count == 16'h0000;
    endproperty
    a_trig: assert property (p_trig) else $error("trigger ignored");

    property p_osc_pins;
        @(posedge clock) disable iff (!arst_n)
        secondary_osc_enable |-> osc_pin_read == 2'h0;
    endproperty
    a_osc_pins: assert property (p_osc_pins) else $error("osc pins not zero");

    property p_internal_rate;
        @(posedge clock) disable iff (!arst_n)
        (!ctrl.clock_source_select && count_tick) |=> !count_tick [*3];
    endproperty
    a_internal_rate: assert property (p_internal_rate) else $error("tick rate wrong");

    // Set beats a status write that would clear the flag in the same cycle
    property p_flag_set_wins;
        @(posedge clock) disable iff (!arst_n)
        (pre_out && !wr_low && !wr_high && !trig_reset && count == SBT_COUNT_MAX)
            |=> overflow_flag;
    endproperty
    a_flag_set_wins: assert property (p_flag_set_wins) else $error("flag not set");

    // A low write and a trigger together keep the written byte
    sequence s_trig_with_write;
        trig_reset && wr_low;
    endsequence

    property p_write_beats_trig;
        @(posedge clock) disable iff (!arst_n)
        s_trig_with_write |=> count[7:0] == $past(req.wdata);
    endproperty
    a_write_beats_trig: assert property (p_write_beats_trig) else $error("write lost");

    // Filtered edge lasts one cycle, so a slow pin counts only once
    property p_sync_single;
        @(posedge clock) disable iff (!arst_n)
        (ctrl.clock_source_select && !ctrl.external_sync_bypass && ext_edge) |=> !ext_edge;
    endproperty
    a_sync_single: assert property (p_sync_single) else $error("double edge");
endmodule

// *** sim/sbt_far_model.sv ***
`timescale 1ns/1ps
// Far side of the timer: count clock pin, oscillator and compare trigger
module sbt_far_model (
    input wire logic clock,
    output logic external_clock_pin,
    output logic sec_osc_clock,
    output logic [3:0] compare_mode_field,
    output logic compare_match
);
    // Count clocks stand low between bursts
    initial begin
        external_clock_pin = 1'b0;
        sec_osc_clock = 1'b0;
        compare_mode_field = 4'h0;
        compare_match = 1'b0;
    end

    // Burst of rising edges on one source, 4 clocks high and 4 low
    // Slower than the 2-clock minimum so the synchroniser never misses one
    task automatic pulses(input int n, input logic osc);
        repeat (n) begin
            sec_osc_clock <= osc;
            external_clock_pin <= !osc;
            repeat (4) @(posedge clock);
            sec_osc_clock <= 1'b0;
            external_clock_pin <= 1'b0;
            repeat (4) @(posedge clock);
        end
    endtask

    // One-cycle compare match under the given mode; mode stays afterwards
    task automatic fire(input logic [3:0] mode);
        compare_mode_field <= mode;
        compare_match <= 1'b1;
        @(posedge clock);
        compare_match <= 1'b0;
    endtask
endmodule

// *** sim/sbt_timer_bench.sv ***
`timescale 1ns/1ps
// Self-checking bench: driver queues notes, monitor compares read data
module sbt_timer_bench;
    import sbt_pkg::*;
    // Note kinds: exact value, store as base, difference from base
    localparam logic [1:0] k_abs = 2'h0;
    localparam logic [1:0] k_base = 2'h1;
    localparam logic [1:0] k_diff = 2'h2;
    typedef struct packed {
        logic [1:0] kind;
        logic [7:0] val;
    } sbt_exp_s;
    logic clock = 1'b0;
    logic arst_n = 1'b0;
    sbt_req_s req = '0;
    logic [7:0] rdata;
    logic external_clock_pin;
    logic sec_osc_clock;
    logic secondary_osc_enable = 1'b0;
    logic [1:0] osc_pin_in = 2'h0;
    logic [1:0] osc_pin_direction_bits = 2'h0;
    logic [1:0] osc_pin_read;
    logic [3:0] compare_mode_field;
    logic compare_match;
    logic compare_timebase_select;
    logic overflow_irq;
    int error_cnt = 0;
    int comparisons = 0;
    sbt_exp_s exp_q[$];
    sbt_exp_s cur_exp;
    logic [7:0] base = 8'h00;
    logic rd_seen = 1'b0;
    logic [7:0] h;
    logic [7:0] l;

    // 20 MHz system clock
    always #25 clock = ~clock;

    sbt_timer u_sbt_timer (
        .clock(clock),
        .arst_n(arst_n),
        .req(req),
        .rdata(rdata),
        .external_clock_pin(external_clock_pin),
        .sec_osc_clock(sec_osc_clock),
        .secondary_osc_enable(secondary_osc_enable),
        .osc_pin_in(osc_pin_in),
        .osc_pin_direction_bits(osc_pin_direction_bits),
        .osc_pin_read(osc_pin_read),
        .compare_mode_field(compare_mode_field),
        .compare_match(compare_match),
        .compare_timebase_select(compare_timebase_select),
        .overflow_irq(overflow_irq)
    );

    sbt_far_model u_sbt_far_model (
        .clock(clock),
        .external_clock_pin(external_clock_pin),
        .sec_osc_clock(sec_osc_clock),
        .compare_mode_field(compare_mode_field),
        .compare_match(compare_match)
    );

    task automatic chk(input logic [7:0] got, input logic [7:0] want);
        comparisons++;
        if (got !== want) begin
            $display("ERROR time %0t got %h expected %h", $time, got, want);
            error_cnt++;
        end
    endtask

    // Bus tasks leave the strobe up; idle drops it, so no double assignment
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clock);
    endtask

    task automatic rd(input logic [1:0] a, input logic [1:0] k, input logic [7:0] v);
        exp_q.push_back('{kind: k, val: v});
        req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clock);
    endtask

    task automatic idle(input int n);
        req <= '0;
        repeat (n) @(posedge clock);
    endtask

    task automatic done(input string s);
        $display("test %s finished", s);
    endtask

    task automatic final_report();
        if (exp_q.size() != 0) error_cnt++;
        $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Read data stands only in the cycle after the strobe, zero otherwise
    always @(posedge clock) begin
        if (!arst_n) begin
            // Read data is unknown until the first clocked reset edge
        end else if (rd_seen && exp_q.size() > 0) begin
            cur_exp = exp_q.pop_front();
            if (cur_exp.kind == k_base) base = rdata;
            else if (cur_exp.kind == k_diff) chk(rdata - base, cur_exp.val);
            else chk(rdata, cur_exp.val);
        end else begin
            chk(rdata, 8'h00);
        end
        rd_seen = req.rd;
    end

    initial begin
        void'($urandom(32'hf2e3eea7));
        repeat (3) @(posedge clock);
        arst_n <= 1'b1;
        @(posedge clock);
        rd(SBT_ADDR_LOW, k_abs, SBT_BYTE_RST);
        rd(SBT_ADDR_HIGH, k_abs, SBT_BYTE_RST);
        rd(SBT_ADDR_CTRL, k_abs, SBT_CTRL_RST);
        rd(SBT_ADDR_STAT, k_abs, 8'h00);
        chk({7'h0, overflow_irq}, 8'h00);
        wr(SBT_ADDR_CTRL, 8'hff);
        rd(SBT_ADDR_CTRL, k_abs, 8'hbf);
        wr(SBT_ADDR_CTRL, 8'h00);
        idle(2);
        done("reset");
        // Narrow mode, counter stopped: bytes independent
        h = 8'($urandom);
        l = 8'($urandom);
        wr(SBT_ADDR_HIGH, h);
        wr(SBT_ADDR_LOW, l);
        rd(SBT_ADDR_LOW, k_abs, l);
        rd(SBT_ADDR_HIGH, k_abs, h);
        wr(SBT_ADDR_HIGH, ~h);
        rd(SBT_ADDR_LOW, k_abs, l);
        rd(SBT_ADDR_HIGH, k_abs, ~h);
        // Wide mode: high address reaches only the buffer
        wr(SBT_ADDR_CTRL, 8'h80);
        wr(SBT_ADDR_HIGH, h);
        rd(SBT_ADDR_HIGH, k_abs, h);
        wr(SBT_ADDR_CTRL, 8'h00);
        rd(SBT_ADDR_HIGH, k_abs, ~h);
        wr(SBT_ADDR_CTRL, 8'h80);
        wr(SBT_ADDR_HIGH, h ^ 8'h5a);
        wr(SBT_ADDR_LOW, ~l);
        wr(SBT_ADDR_HIGH, h);
        rd(SBT_ADDR_LOW, k_abs, ~l);
        rd(SBT_ADDR_HIGH, k_abs, h ^ 8'h5a);
        wr(SBT_ADDR_CTRL, 8'h00);
        rd(SBT_ADDR_HIGH, k_abs, h ^ 8'h5a);
        idle(1);
        done("byte access");
        // Five prescaled ticks between two reads, every prescale code
        for (int c = 0; c < 4; c++) begin
            wr(SBT_ADDR_CTRL, 8'h01 | 8'(c << 4));
            idle(64);
            rd(SBT_ADDR_LOW, k_base, 8'h00);
            idle(5 * SBT_INSTR_DIV * (1 << c) - 1);
            rd(SBT_ADDR_LOW, k_diff, 8'h05);
        end
        wr(SBT_ADDR_CTRL, 8'h00);
        rd(SBT_ADDR_LOW, k_base, 8'h00);
        idle(40);
        rd(SBT_ADDR_LOW, k_diff, 8'h00);
        // Mid-period byte write at 1:8; only a low write restarts it
        for (int i = 0; i < 2; i++) begin
            wr(SBT_ADDR_CTRL, 8'h31);
            wr(SBT_ADDR_LOW, 8'h00);
            idle(15);
            wr(i ? SBT_ADDR_LOW : SBT_ADDR_HIGH, 8'h00);
            idle(23);
            rd(SBT_ADDR_LOW, k_abs, i ? 8'h00 : 8'h01);
        end
        idle(1);
        done("timer");
        // Wrap from the top value sets the sticky flag
        wr(SBT_ADDR_CTRL, 8'h00);
        wr(SBT_ADDR_STAT, 8'h02);
        wr(SBT_ADDR_HIGH, SBT_COUNT_MAX[15:8]);
        wr(SBT_ADDR_LOW, SBT_COUNT_MAX[7:0] - 8'h01);
        wr(SBT_ADDR_CTRL, 8'h01);
        idle(1);
        for (int n = 0; n < 40 && overflow_irq !== 1'b1; n++) @(posedge clock);
        chk({7'h0, overflow_irq}, 8'h01);
        if (overflow_irq !== 1'b1) final_report();
        wr(SBT_ADDR_CTRL, 8'h00);
        rd(SBT_ADDR_STAT, k_abs, 8'h03);
        rd(SBT_ADDR_HIGH, k_abs, 8'h00);
        wr(SBT_ADDR_STAT, 8'h01);
        rd(SBT_ADDR_STAT, k_abs, 8'h01);
        idle(1);
        chk({7'h0, overflow_irq}, 8'h00);
        wr(SBT_ADDR_STAT, 8'h00);
        rd(SBT_ADDR_STAT, k_abs, 8'h00);
        idle(1);
        done("overflow");
        // Trigger: wrong mode, special mode, timebase not selected
        for (int t = 0; t < 3; t++) begin
            wr(SBT_ADDR_CTRL, t == 2 ? 8'h01 : 8'h09);
            wr(SBT_ADDR_HIGH, 8'h12);
            wr(SBT_ADDR_LOW, 8'h00);
            idle(1);
            chk({7'h0, compare_timebase_select}, t == 2 ? 8'h00 : 8'h01);
            u_sbt_far_model.fire(t == 0 ? 4'ha : SBT_MODE_SPECIAL);
            rd(SBT_ADDR_HIGH, k_abs, t == 1 ? 8'h00 : 8'h12);
        end
        // Write in the trigger cycle wins
        wr(SBT_ADDR_CTRL, 8'h09);
        wr(SBT_ADDR_HIGH, 8'h12);
        fork
            wr(SBT_ADDR_LOW, 8'h34);
            u_sbt_far_model.fire(SBT_MODE_SPECIAL);
        join
        rd(SBT_ADDR_HIGH, k_abs, 8'h12);
        idle(1);
        done("trigger");
        // External pin, synchronised, then oscillator unsynchronised
        osc_pin_in <= 2'h3;
        osc_pin_direction_bits <= 2'($urandom);
        wr(SBT_ADDR_CTRL, 8'h03);
        rd(SBT_ADDR_LOW, k_base, 8'h00);
        // Pin filter needs three stages plus agreement before it shows
        idle(3);
        chk({6'h0, osc_pin_read}, 8'h03);
        u_sbt_far_model.pulses(5, 1'b0);
        idle(8);
        rd(SBT_ADDR_LOW, k_diff, 8'h05);
        secondary_osc_enable <= 1'b1;
        wr(SBT_ADDR_CTRL, 8'h07);
        idle(1);
        chk({6'h0, osc_pin_read}, 8'h00);
        rd(SBT_ADDR_LOW, k_base, 8'h00);
        idle(1);
        u_sbt_far_model.pulses(3, 1'b1);
        idle(8);
        rd(SBT_ADDR_LOW, k_diff, 8'h03);
        idle(2);
        done("external");
        final_report();
    end
endmodule
